// ==== verilog/ssi_cfg.svh ====
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH
// Behaviour
// (RULE1) Momentary status bits are read-only and show the live condition.
// (RULE2) Several conditions also keep a latched copy beside the live bit.
// (RULE3) A latched bit stays set until software writes 1 to it.
// (RULE4) A write-1 clear only works once the condition is gone; else it re-sets.
// (RULE5) A latched bit drives the interrupt only with its enable at 1.
// (RULE6) An enabled latched bit pulls the active-low interrupt pin; a lock bit here also needs the other lock enable.
// (RULE7) The interrupt pin releases once every enabled latched source is cleared.
// (RULE8) Both lock status bits read 1 when locked, 0 on loss; latched alike.
// (RULE9) Calibration status is momentary only, no latch and no enable.
// (RULE10) Reference bit reads 0 when lost, and in auto mode during selection.
// (RULE11) Holdover modes: reference bit 0 while holdover persists after loss/change.
// (RULE12) Lock pin is 1 only when both latched lock bits show locked.
// (RULE13) Lock-loss interrupts need both lock interrupt enables set.
// (RULE14) Power-on reset loads all defaults; clock outputs come up disabled.
// (RULE15) Force bit holds the VCXO control centred until cleared.
// (RULE16) Divider-sync write realigns all dividers and delays, then self-clears.
// (RULE17) Host writes pll_lock_restart and calibrate apart from the divider-sync write.
// (RULE18) Host follows the recommended bring-up order ending with output enable.
// (RULE19) Stage-one lock detection works only while the force bit is 0.
// (RULE20) With no validated input, clearing the latched reference bit does nothing.
// (RULE21) Writing 0 to latched bits changes nothing; momentary bits ignore writes.
// (RULE22) Interrupt pin low when any latched bit AND enable is true; a lock bit here also needs the other lock enable.
// (RULE23) Self-clearing command bits read 0 once their action is launched.

`define SSI_SRC_N 6
`define SSI_B_IN0 0
`define SSI_B_IN1 1
`define SSI_B_LK1 2
`define SSI_B_LK2 3
`define SSI_B_HOLD 4
`define SSI_B_REF 5

`define SSI_IE_RST 6'h00
`define SSI_FAULT_RST 6'h00
`define SSI_FORCE_RST 1'h1
`define SSI_OUTEN_RST 1'h0
`define SSI_SDO_RST 1'h0
`define SSI_LVL_RST 1'h0

`define SSI_CLK_NS 8
`define SSI_SYNC_NS 40
`define SSI_SYNC_CYC ((`SSI_SYNC_NS + `SSI_CLK_NS - 1) / `SSI_CLK_NS)
`endif

// ==== verilog/ssi_pkg.sv ====
package ssi_pkg;
    typedef enum logic [1:0] {
        SSI_MODE_MANUAL = 2'h0,
        SSI_MODE_AUTO = 2'h1,
        SSI_MODE_MAN_HOLD = 2'h2,
        SSI_MODE_AUTO_HOLD = 2'h3
    } ssi_mode_e;

    typedef enum logic [1:0] {
        SSI_SYNC_IDLE = 2'h0,
        SSI_SYNC_RUN = 2'h1,
        SSI_SYNC_DONE = 2'h3
    } ssi_sync_e;

    // bit order matches the source positions in the cfg header
    typedef struct packed {
        logic reference_valid;
        logic not_holdover;
        logic stage2_locked;
        logic stage1_locked;
        logic input1_active;
        logic input0_active;
    } ssi_src_s;

    typedef struct packed {
        logic vcxo_force_centre;
        logic serial_out_pin_mode;
        logic status_pin_level_sel;
        logic outputs_enable;
    } ssi_ctrl_s;

    typedef struct packed {
        logic div_sync_start;
        logic pll_lock_restart;
        logic vco_band_calibrate;
    } ssi_cmd_s;
endpackage

// ==== verilog/ssi_top.sv ====
`timescale 1ns/10ps
`include "ssi_cfg.svh"

module ssi_top #(
    parameter int SRC_N = `SSI_SRC_N
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // monitored conditions
    input wire logic input0_active_i,
    input wire logic input1_active_i,
    input wire logic stage1_phase_ok_i,
    input wire logic stage2_locked_i,
    input wire logic holdover_i,
    input wire logic vco_cal_done_i,
    input wire logic selected_input_i,
    input wire logic ref_lost_i,
    input wire logic selecting_i,
    input wire logic manual_change_i,
    input wire ssi_pkg::ssi_mode_e ref_mode_i,
    // software writes
    input wire ssi_pkg::ssi_src_s sticky_clr_i,
    input wire logic irq_enable_wr_i,
    input wire ssi_pkg::ssi_src_s irq_enable_i,
    input wire logic ctrl_wr_i,
    input wire ssi_pkg::ssi_ctrl_s ctrl_i,
    input wire logic cmd_wr_i,
    input wire ssi_pkg::ssi_cmd_s cmd_i,
    // status readback
    output ssi_pkg::ssi_src_s now_o,
    output ssi_pkg::ssi_src_s sticky_o,
    output logic vco_cal_status_o,
    output logic selected_input_now_o,
    output ssi_pkg::ssi_src_s irq_enable_o,
    output ssi_pkg::ssi_ctrl_s ctrl_o,
    output ssi_pkg::ssi_cmd_s cmd_o,
    // device pins and actions
    output logic irq_out_n_o,
    output logic lock_o,
    output logic vcxo_tune_pin_centre_o,
    output logic div_sync_o,
    output logic pll_lock_restart_o,
    output logic vco_band_calibrate_o
);

////////////////////////////////////////////////////////////////////////////////

logic [SRC_N-1:0] live;
logic [SRC_N-1:0] cond;
logic [SRC_N-1:0] clr_eff;
logic [SRC_N-1:0] eff_en;
logic [SRC_N-1:0] fault_r;
logic [SRC_N-1:0] fault_nxt;
logic [SRC_N-1:0] now_r;
logic [SRC_N-1:0] now_nxt;
logic [SRC_N-1:0] ie_r;
logic [SRC_N-1:0] ie_nxt;
logic ref_ok;
logic any_input;
logic cal_r;
logic cal_nxt;
logic sel_r;
logic sel_nxt;
logic irq_n_r;
logic irq_n_nxt;
logic lock_r;
logic lock_nxt;
ssi_pkg::ssi_ctrl_s ctrl_r;
ssi_pkg::ssi_ctrl_s ctrl_nxt;

////////////////////////////////////////////////////////////////////////////////
// live conditions

always_comb begin
    unique case (ref_mode_i)
        ssi_pkg::SSI_MODE_MANUAL: ref_ok = !ref_lost_i; // see (RULE10)
        ssi_pkg::SSI_MODE_AUTO: ref_ok = !ref_lost_i && !selecting_i; // see (RULE10)
        ssi_pkg::SSI_MODE_MAN_HOLD: ref_ok = !(manual_change_i && holdover_i); // see (RULE11)
        ssi_pkg::SSI_MODE_AUTO_HOLD: ref_ok = !(ref_lost_i && holdover_i); // see (RULE11)
    endcase
end

always_comb begin
    live = '0;
    live[`SSI_B_IN0] = input0_active_i;
    live[`SSI_B_IN1] = input1_active_i;
    // detector idle while the tune voltage is forced
    live[`SSI_B_LK1] = stage1_phase_ok_i && !ctrl_r.vcxo_force_centre; // see (RULE19) (RULE8)
    live[`SSI_B_LK2] = stage2_locked_i; // see (RULE8)
    live[`SSI_B_HOLD] = !holdover_i;
    live[`SSI_B_REF] = ref_ok;
end

assign any_input = input0_active_i || input1_active_i;
assign cond = ~live;

always_comb begin
    clr_eff = sticky_clr_i;
    if (!any_input) begin
        clr_eff[`SSI_B_REF] = 1'h0; // see (RULE20)
    end
end

////////////////////////////////////////////////////////////////////////////////
// momentary copies, registered once

always_comb begin
    now_nxt = live; // see (RULE1)
    cal_nxt = !vco_cal_done_i; // see (RULE9)
    sel_nxt = selected_input_i;
end

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        now_r <= '0;
        cal_r <= 1'h0;
        sel_r <= 1'h0;
    end else begin
        now_r <= now_nxt;
        cal_r <= cal_nxt;
        sel_r <= sel_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// latched faults: fault_r high means the sticky bit reads 0

genvar g;
generate
    for (g = 0; g < SRC_N; g++) begin : g_src
        always_comb begin
            // set wins over a same-cycle clear
            fault_nxt[g] = cond[g] || (fault_r[g] && !clr_eff[g]); // see (RULE2) (RULE3) (RULE4) (RULE21)
        end
    end
endgenerate

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        fault_r <= `SSI_FAULT_RST;
    end else begin
        fault_r <= fault_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// enables, interrupt pin and lock pin

always_comb begin
    ie_nxt = ie_r;
    if (irq_enable_wr_i) begin
        ie_nxt = irq_enable_i;
    end
end

always_comb begin
    eff_en = ie_nxt;
    // lock sources only when both lock enables are set
    eff_en[`SSI_B_LK1] = ie_nxt[`SSI_B_LK1] && ie_nxt[`SSI_B_LK2]; // see (RULE13)
    eff_en[`SSI_B_LK2] = eff_en[`SSI_B_LK1]; // see (RULE13)
    irq_n_nxt = ~|(fault_nxt & eff_en); // see (RULE5) (RULE6) (RULE7) (RULE22)
    lock_nxt = !fault_nxt[`SSI_B_LK1] && !fault_nxt[`SSI_B_LK2]; // see (RULE12)
end

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        ie_r <= `SSI_IE_RST;
        irq_n_r <= 1'h1;
        lock_r <= 1'h1;
    end else begin
        ie_r <= ie_nxt;
        irq_n_r <= irq_n_nxt;
        lock_r <= lock_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// control bits

always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr_i) begin
        ctrl_nxt = ctrl_i;
    end
end

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        ctrl_r.vcxo_force_centre <= `SSI_FORCE_RST; // see (RULE14) (RULE15)
        ctrl_r.serial_out_pin_mode <= `SSI_SDO_RST;
        ctrl_r.status_pin_level_sel <= `SSI_LVL_RST;
        ctrl_r.outputs_enable <= `SSI_OUTEN_RST; // see (RULE14)
    end else begin
        ctrl_r <= ctrl_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// self-clearing commands and divider sync sequence

localparam logic [7:0] SYNC_CYC = 8'(`SSI_SYNC_CYC);

ssi_pkg::ssi_sync_e state_r;
ssi_pkg::ssi_sync_e state_nxt;
logic [7:0] cnt_r;
logic [7:0] cnt_nxt;
ssi_pkg::ssi_cmd_s cmd_r;
ssi_pkg::ssi_cmd_s cmd_nxt;
logic sync_r;
logic sync_nxt;
logic pll_lock_restart_r;
logic pll_lock_restart_nxt;
logic calib_r;
logic calib_nxt;

always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    pll_lock_restart_nxt = cmd_r.pll_lock_restart;
    calib_nxt = cmd_r.vco_band_calibrate;
    cmd_nxt.pll_lock_restart = 1'h0; // see (RULE23)
    cmd_nxt.vco_band_calibrate = 1'h0; // see (RULE23)
    unique case (state_r)
        ssi_pkg::SSI_SYNC_IDLE: begin
            if (cmd_r.div_sync_start) begin
                state_nxt = ssi_pkg::SSI_SYNC_RUN; // see (RULE16)
                cnt_nxt = SYNC_CYC - 8'h01;
                cmd_nxt.div_sync_start = 1'h0; // see (RULE16) (RULE23)
            end
        end
        ssi_pkg::SSI_SYNC_RUN: begin
            if (cnt_r == 8'h00) begin
                state_nxt = ssi_pkg::SSI_SYNC_DONE;
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
        ssi_pkg::SSI_SYNC_DONE: state_nxt = ssi_pkg::SSI_SYNC_IDLE;
        default: state_nxt = ssi_pkg::SSI_SYNC_IDLE;
    endcase
    // a new write is kept pending; set wins over self-clear
    if (cmd_wr_i) begin
        cmd_nxt = cmd_nxt | cmd_i;
    end
    sync_nxt = state_nxt == ssi_pkg::SSI_SYNC_RUN;
end

always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
        state_r <= ssi_pkg::SSI_SYNC_IDLE;
        cnt_r <= 8'h00;
        cmd_r <= '0;
        sync_r <= 1'h0;
        pll_lock_restart_r <= 1'h0;
        calib_r <= 1'h0;
    end else begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        cmd_r <= cmd_nxt;
        sync_r <= sync_nxt;
        pll_lock_restart_r <= pll_lock_restart_nxt;
        calib_r <= calib_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign now_o = ssi_pkg::ssi_src_s'(now_r);
assign sticky_o = ssi_pkg::ssi_src_s'(~fault_r); // see (RULE8)
assign vco_cal_status_o = cal_r;
assign selected_input_now_o = sel_r;
assign irq_enable_o = ssi_pkg::ssi_src_s'(ie_r);
assign ctrl_o = ctrl_r;
assign cmd_o = cmd_r;
assign irq_out_n_o = irq_n_r;
assign lock_o = lock_r;
assign vcxo_tune_pin_centre_o = ctrl_r.vcxo_force_centre; // see (RULE15)
assign div_sync_o = sync_r;
assign pll_lock_restart_o = pll_lock_restart_r;
assign vco_band_calibrate_o = calib_r;

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);

sequence sync_req;
    cmd_wr_i && cmd_i.div_sync_start && state_r == ssi_pkg::SSI_SYNC_IDLE;
endsequence

sequence sync_launch;
    div_sync_o && !cmd_o.div_sync_start ##1 div_sync_o;
endsequence

sequence pll_lock_restart_req;
    cmd_wr_i && cmd_i.pll_lock_restart ##1 !cmd_wr_i;
endsequence

now_live_a: assert property (!$past(rst_i) |-> now_r == $past(live)) // see (RULE1)
    else $error("momentary status not live");

sticky_hold_a: assert property (##1 ($past(fault_r & ~clr_eff) & ~fault_r) == '0) // see (RULE3)
    else $error("latched bit dropped without clear");

set_wins_a: assert property (!$past(rst_i) |-> ($past(cond) & ~fault_r) == '0) // see (RULE4)
    else $error("active condition not latched");

clear_works_a: assert property (##1 ($past(clr_eff & ~cond) & fault_r) == '0) // see (RULE21)
    else $error("write-1 clear ignored");

ref_clear_blocked_a: assert property (
    (!any_input && fault_r[`SSI_B_REF]) |=> fault_r[`SSI_B_REF]) // see (RULE20)
    else $error("reference latch cleared with no input");

irq_masked_a: assert property (ie_r == '0 |-> irq_out_n_o) // see (RULE5)
    else $error("interrupt with all enables off");

irq_lock_pair_a: assert property (
    (fault_r == (6'h01 << `SSI_B_LK1) && !ie_r[`SSI_B_LK2]) |-> irq_out_n_o) // see (RULE13)
    else $error("lock interrupt with one enable");

irq_level_a: assert property (irq_out_n_o == !(|(fault_r & ie_r & ~6'h0c)
    || (ie_r[`SSI_B_LK1] && ie_r[`SSI_B_LK2] && |fault_r[3:2]))) // see (RULE22)
    else $error("interrupt pin mismatch");

lock_pin_a: assert property (lock_o == (sticky_o.stage1_locked && sticky_o.stage2_locked)) // see (RULE12)
    else $error("lock pin mismatch");

force_gate_a: assert property (ctrl_r.vcxo_force_centre |=> !now_o.stage1_locked) // see (RULE19)
    else $error("stage one locked while forced");

sync_start_a: assert property ((sync_req ##1 !cmd_wr_i) |=> sync_launch) // see (RULE16)
    else $error("divider sync not launched");

pll_lock_restart_pulse_a: assert property (pll_lock_restart_req |=> pll_lock_restart_o && !cmd_o.pll_lock_restart) // see (RULE23)
    else $error("pll_lock_restart bit not self-cleared");

endmodule

// ==== testbench/ssi_host.sv ====
`timescale 1ns/10ps
module ssi_host (
    // clock
    input wire logic clk_i,
    // software writes into the device
    output ssi_pkg::ssi_src_s sticky_clr_o,
    output logic irq_enable_wr_o,
    output ssi_pkg::ssi_src_s irq_enable_o,
    output logic ctrl_wr_o,
    output ssi_pkg::ssi_ctrl_s ctrl_o,
    output logic cmd_wr_o,
    output ssi_pkg::ssi_cmd_s cmd_o
);
    initial begin
        sticky_clr_o = 6'h00;
        irq_enable_wr_o = 1'h0;
        irq_enable_o = 6'h2a;
        ctrl_wr_o = 1'h0;
        ctrl_o = 4'h5;
        cmd_wr_o = 1'h0;
        cmd_o = 3'h5;
    end
    ////////////////////////////////////////////////////////////////////
    // released data is inverted so a stale value is never trusted; wr_clr returns to 6'h00 instead
    task automatic wr_clr(input ssi_pkg::ssi_src_s v);
        @(posedge clk_i);
        sticky_clr_o <= v;
        @(posedge clk_i);
        sticky_clr_o <= 6'h00;
    endtask
    task automatic wr_ie(input ssi_pkg::ssi_src_s v);
        @(posedge clk_i);
        irq_enable_wr_o <= 1'h1;
        irq_enable_o <= v;
        @(posedge clk_i);
        irq_enable_wr_o <= 1'h0;
        irq_enable_o <= ~v;
    endtask
    task automatic wr_ctrl(input ssi_pkg::ssi_ctrl_s v);
        @(posedge clk_i);
        ctrl_wr_o <= 1'h1;
        ctrl_o <= v;
        @(posedge clk_i);
        ctrl_wr_o <= 1'h0;
        ctrl_o <= ~v;
    endtask
    task automatic wr_cmd(input ssi_pkg::ssi_cmd_s v);
        @(posedge clk_i);
        cmd_wr_o <= 1'h1;
        cmd_o <= v;
        @(posedge clk_i);
        cmd_wr_o <= 1'h0;
        cmd_o <= ~v;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic bringup;
        wr_ctrl(4'hc);
        wr_cmd(3'h4);
        repeat (8) @(posedge clk_i);
        wr_cmd(3'h3);
        wr_ctrl(4'h6);
        repeat (2) @(posedge clk_i);
        wr_clr(6'h3f);
        wr_ctrl(4'h7);
    endtask
endmodule

// ==== testbench/status_interrupt_startup_tb.sv ====
`timescale 1ns/10ps
module status_interrupt_startup_tb;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [5:0] cond = 6'h3f;
    logic [1:0] mode = 2'h0;
    logic cal_done = 1'h0;
    logic sel_in = 1'h0;
    logic selecting;
    logic chg;
    ssi_pkg::ssi_src_s clr, ie_v, now_o, sticky_o, irq_enable_o;
    ssi_pkg::ssi_ctrl_s ctrl_v, ctrl_o;
    ssi_pkg::ssi_cmd_s cmd_v, cmd_o;
    logic ie_wr, ctrl_wr, cmd_wr, vco_cal_status_o, selected_input_now_o;
    logic irq_out_n_o, lock_o, vcxo_tune_pin_centre_o, div_sync_o, rl_o, cal_o;
    int n_mismatch = 0;
    int checked = 0;
    int n_sync, n_rl, n_cal;
    // mode, reference good, selecting, change, not holdover, expected
    logic [6:0] tbl [6] = '{7'h1b, 7'h3a, 7'h41, 7'h54, 7'h63, 7'h60};

    always #4 clk_i = ~clk_i;

    ssi_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .input0_active_i(cond[0]),
        .input1_active_i(cond[1]), .stage1_phase_ok_i(cond[2]), .stage2_locked_i(cond[3]),
        .holdover_i(~cond[4]), .vco_cal_done_i(cal_done), .selected_input_i(sel_in),
        .ref_lost_i(~cond[5]), .selecting_i(selecting), .manual_change_i(chg),
        .ref_mode_i(ssi_pkg::ssi_mode_e'(mode)), .sticky_clr_i(clr),
        .irq_enable_wr_i(ie_wr), .irq_enable_i(ie_v), .ctrl_wr_i(ctrl_wr), .ctrl_i(ctrl_v),
        .cmd_wr_i(cmd_wr), .cmd_i(cmd_v), .now_o(now_o), .sticky_o(sticky_o),
        .vco_cal_status_o(vco_cal_status_o), .selected_input_now_o(selected_input_now_o),
        .irq_enable_o(irq_enable_o), .ctrl_o(ctrl_o), .cmd_o(cmd_o),
        .irq_out_n_o(irq_out_n_o), .lock_o(lock_o),
        .vcxo_tune_pin_centre_o(vcxo_tune_pin_centre_o), .div_sync_o(div_sync_o),
        .pll_lock_restart_o(rl_o), .vco_band_calibrate_o(cal_o));

    ssi_host host_u (.clk_i(clk_i), .sticky_clr_o(clr), .irq_enable_wr_o(ie_wr),
        .irq_enable_o(ie_v), .ctrl_wr_o(ctrl_wr), .ctrl_o(ctrl_v), .cmd_wr_o(cmd_wr),
        .cmd_o(cmd_v));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        selecting = 1'h0;
        chg = 1'h0;
        w(1);
        chk("reset sticky", 8'h3f, sticky_o);
        chk("reset pins", 8'h0e, {irq_out_n_o, lock_o, vcxo_tune_pin_centre_o,
            div_sync_o});
        chk("reset ctrl cmd", 8'h40, {ctrl_o, cmd_o});
        chk("reset enables", 8'h00, irq_enable_o);
        @(posedge clk_i);
        rst_i <= 1'h0;
        $display("test reset done");
        n_sync = 0;
        n_rl = 0;
        n_cal = 0;
        fork
            host_u.bringup();
            for (int i = 0; i < 40; i++) begin
                w(1);
                n_sync += int'(div_sync_o);
                n_rl += int'(rl_o);
                n_cal += int'(cal_o);
            end
        join
        chk("sync cycles", 8'd5, n_sync[7:0]);
        chk("restart pulses", 8'h11, {n_rl[3:0], n_cal[3:0]});
        chk("cmd readback", 8'h00, cmd_o);
        chk("ctrl", 8'h07, ctrl_o);
        chk("tune centre", 8'h00, vcxo_tune_pin_centre_o);
        chk("sticky", 8'h3f, sticky_o);
        chk("lock irq", 8'h03, {lock_o, irq_out_n_o});
        $display("test bringup done");
        host_u.wr_ie(6'h3f);
        w(0);
        chk("enables", 8'h3f, irq_enable_o);
        for (int b = 0; b < 6; b++) begin
            @(posedge clk_i);
            cond[b] <= 1'h0;
            w(2);
            chk("live bit", 8'h00, now_o[b]);
            chk("sticky bit", 8'h00, sticky_o[b]);
            chk("irq pin", 8'h00, irq_out_n_o);
            chk("lock pin", {7'h0, b > 3 || b < 2}, lock_o);
            host_u.wr_clr(6'h01 << b);
            w(1);
            chk("clear refused", 8'h00, sticky_o[b]);
            @(posedge clk_i);
            cond[b] <= 1'h1;
            w(2);
            chk("sticky held", 8'h00, sticky_o[b]);
            host_u.wr_clr(~(6'h01 << b));
            w(1);
            chk("zero write", 8'h00, sticky_o[b]);
            chk("irq held", 8'h00, irq_out_n_o);
            host_u.wr_clr(6'h01 << b);
            w(1);
            chk("cleared", 8'h01, sticky_o[b]);
            chk("irq released", 8'h01, irq_out_n_o);
        end
        $display("test latch done");
        host_u.wr_ie(6'h04);
        @(posedge clk_i);
        cond[2] <= 1'h0;
        w(2);
        chk("one lock enable", 8'h01, irq_out_n_o);
        host_u.wr_ie(6'h00);
        w(1);
        chk("all masked", 8'h01, irq_out_n_o);
        host_u.wr_ie(6'h0c);
        w(1);
        chk("both lock enables", 8'h00, irq_out_n_o);
        @(posedge clk_i);
        cond <= 6'h1c;
        w(2);
        @(posedge clk_i);
        cond[5] <= 1'h1;
        w(2);
        host_u.wr_clr(6'h20);
        w(1);
        chk("ref clear no input", 8'h00, sticky_o[5]);
        @(posedge clk_i);
        cond <= 6'h3f;
        w(2);
        host_u.wr_clr(6'h3f);
        w(1);
        chk("all clear", 8'h3f, sticky_o);
        chk("irq off", 8'h01, irq_out_n_o);
        $display("test mask done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            mode <= tbl[i][6:5];
            cond[5] <= tbl[i][4];
            selecting <= tbl[i][3];
            chg <= tbl[i][2];
            cond[4] <= tbl[i][1];
            cal_done <= i[0];
            sel_in <= i[1];
            w(2);
            chk("ref per mode", {7'h0, tbl[i][0]}, now_o.reference_valid);
            chk("cal status", {7'h0, ~i[0]}, vco_cal_status_o);
            chk("selected input", {7'h0, i[1]}, selected_input_now_o);
        end
        $display("test modes done");
        conclude();
    end
endmodule
